// ---- hdl/vectored_interrupt_map.vh ----
`ifndef VECTORED_INTERRUPT_MAP_VH
`define VECTORED_INTERRUPT_MAP_VH

// Source and level counts
`define NUM_SOURCES    512
`define NUM_LEVELS     16
`define NUM_WORDS      16
`define NUM_PRIO_WORDS 64

// Byte offsets
`define RAW_BASE       12'h000
`define EN_BASE        12'h040
`define FSEL_BASE      12'h080
`define PRIO_BASE      12'h100
`define FIQ_VEC_OFF    12'h200
`define IRQ_VEC_OFF    12'h204
`define FIQ_ACT_OFF    12'h208
`define IRQ_ACT_OFF    12'h20C

// Address fields
`define BANK_MSB       11
`define BANK_LSB       6
`define PRIO_SEL_MSB   11
`define PRIO_SEL_LSB   8

// Vector word fields
`define VEC_VALID_BIT  31
`define VEC_LVL_LSB    16
`define VEC_NUM_LSB    0

// Reset values
`define RST_WORD       32'h0000_0000
`define RST_ACT        16'h0000

`endif

// ---- hdl/prio_pick.v ----
`timescale 1ns/100ps
module prio_pick
(
  // Candidate sources and their levels
  input  wire [511:0]  req_in,
  input  wire [2047:0] prio_in,
  // Winner
  output reg           valid_out,
  output reg  [8:0]    num_out,
  output reg  [3:0]    level_out
);

  reg [9:0] k;
  reg [3:0] lev;

  // Lowest level wins, lowest index breaks a tie
  always @*
  begin
    valid_out = 1'b0;
    num_out   = 9'h000;
    level_out = 4'hF;
    lev       = 4'h0;
    for (k = 10'h000; k < 10'h200; k = k + 10'h001)
    begin
      lev = prio_in[{k[8:0], 2'b00} +: 4];
      if (req_in[k[8:0]] && (!valid_out || lev < level_out))
      begin
        valid_out = 1'b1;
        num_out   = k[8:0];
        level_out = lev;
      end
    end
  end

endmodule

// ---- hdl/vectored_interrupt_unit.v ----
// Contract
// - A functional read of a vector register acknowledges the interrupt shown.
// - A debug read returns the same data but changes no state.
// - A pending level above every active level preempts the running handler.
// - A repeat of the same high interrupt may preempt again after its EOI.
// - Another interrupt nesting in between leaves later preemption unaffected.
// - Vector-port acknowledge and register read acknowledge share one state.
// - Fast and normal channels nest by the same logic.
// - 512 sources, each with one of 16 levels, level zero highest.
// - Writing one to a raw bit sets it pending, writing zero clears it.
// - Reading a vector register acknowledges, writing it ends the interrupt.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`include "vectored_interrupt_map.vh"
module vectored_interrupt_unit
(
  // Clock and reset
  input  wire         clk_in,
  input  wire         rst_b_in,
  // Interrupt sources, asynchronous; a synchronized rising edge sets pending
  input  wire [511:0] src_in,
  // Avalon-MM slave
  input  wire [11:0]  address_in,
  input  wire         read_in,
  input  wire         write_in,
  input  wire [31:0]  writedata_in,
  input  wire [3:0]   byteenable_in,
  input  wire         debug_access_in,
  output wire [31:0]  readdata_out,
  output wire         waitrequest_out,
  // Fast interrupt vector port
  input  wire         fiq_ack_in,
  output wire         fiq_req_out,
  output wire [8:0]   fiq_num_out,
  output wire [3:0]   fiq_level_out,
  // Normal interrupt vector port
  input  wire         irq_ack_in,
  output wire         irq_req_out,
  output wire [8:0]   irq_num_out,
  output wire [3:0]   irq_level_out
);

  reg  [511:0]  src_s1_r;
  reg  [511:0]  src_s2_r;
  reg  [511:0]  src_s3_r;
  reg  [511:0]  raw_r;
  reg  [511:0]  en_r;
  reg  [511:0]  fsel_r;
  reg  [2047:0] prio_r;
  reg           wait_r;
  reg  [31:0]   rdata_r;
  reg  [31:0]   rdata_nxt;

  wire [511:0]  raw_nxt;
  wire [511:0]  en_nxt;
  wire [511:0]  fsel_nxt;
  wire [2047:0] prio_nxt;
  wire [511:0]  src_rise;
  wire [511:0]  ack_clr;
  wire [31:0]   bmask;
  wire          rd_fire;
  wire          wr_fire;
  wire [11:0]   bank;
  wire [11:0]   psel;
  wire [1:0]    ack;
  wire [1:0]    eoi;
  wire [1:0]    vec_rd;
  wire [1:0]    core_ack;
  wire [1:0]    req_w;
  wire [17:0]   num_w;
  wire [7:0]    lvl_w;
  wire [31:0]   act_w;
  wire [1023:0] ack_vec;

  // Request taken in the cycle waitrequest is high
  assign rd_fire  = read_in && wait_r;
  assign wr_fire  = write_in && wait_r;
  // Widened to offset width so decode compares match
  assign bank     = {6'h00, address_in[`BANK_MSB:`BANK_LSB]};
  assign psel     = {8'h00, address_in[`PRIO_SEL_MSB:`PRIO_SEL_LSB]};
  assign bmask    = {{8{byteenable_in[3]}}, {8{byteenable_in[2]}},
                     {8{byteenable_in[1]}}, {8{byteenable_in[0]}}};
  assign src_rise = src_s2_r & ~src_s3_r;
  assign core_ack = {irq_ack_in, fiq_ack_in};

  // Debug reads are side-effect free
  assign vec_rd[0] = rd_fire && !debug_access_in &&
                     address_in == `FIQ_VEC_OFF;
  assign vec_rd[1] = rd_fire && !debug_access_in &&
                     address_in == `IRQ_VEC_OFF;
  assign eoi[0]    = wr_fire && address_in == `FIQ_VEC_OFF;
  assign eoi[1]    = wr_fire && address_in == `IRQ_VEC_OFF;

  // Source clear on acknowledge; raw edge set wins below
  assign ack_clr = ack_vec[511:0] | ack_vec[1023:512];

  genvar w;
  genvar c;

  // Word-wide banks with byte lanes
  generate
    for (w = 0; w < `NUM_WORDS; w = w + 1)
    begin : g_word
      wire hit = {28'h0, address_in[5:2]} == w;
      wire wr_raw  = wr_fire && bank == `RAW_BASE >> 6 && hit;
      wire wr_en   = wr_fire && bank == `EN_BASE >> 6 && hit;
      wire wr_fsel = wr_fire && bank == `FSEL_BASE >> 6 && hit;
      wire [31:0] raw_old = raw_r[32*w +: 32];
      wire [31:0] raw_wr  = wr_raw ?
                            ((raw_old & ~bmask) | (writedata_in & bmask)) :
                            raw_old;
      assign raw_nxt[32*w +: 32] = (raw_wr & ~ack_clr[32*w +: 32]) |
                                   src_rise[32*w +: 32];
      assign en_nxt[32*w +: 32] = wr_en ?
        ((en_r[32*w +: 32] & ~bmask) | (writedata_in & bmask)) :
        en_r[32*w +: 32];
      assign fsel_nxt[32*w +: 32] = wr_fsel ?
        ((fsel_r[32*w +: 32] & ~bmask) | (writedata_in & bmask)) :
        fsel_r[32*w +: 32];
    end
    for (w = 0; w < `NUM_PRIO_WORDS; w = w + 1)
    begin : g_prio
      wire wr_p = wr_fire && psel == `PRIO_BASE >> 8 &&
                  {26'h0, address_in[7:2]} == w;
      // Eight 4-bit levels per word
      assign prio_nxt[32*w +: 32] = wr_p ?
        ((prio_r[32*w +: 32] & ~bmask) | (writedata_in & bmask)) :
        prio_r[32*w +: 32];
    end
  endgenerate

  // Per-channel nesting; channel 0 fast, channel 1 normal
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_chan
      reg  [15:0] act_r;
      reg  [15:0] act_nxt;
      reg         req_r;
      reg  [8:0]  num_r;
      reg  [3:0]  lvl_r;
      reg  [4:0]  ceil;
      reg  [4:0]  j;
      wire        pk_valid;
      wire [8:0]  pk_num;
      wire [3:0]  pk_lvl;
      wire [511:0] elig = raw_r & en_r & (c == 0 ? fsel_r : ~fsel_r);
      wire         preempt;

      prio_pick u_pick
      (
        .req_in    (elig),
        .prio_in   (prio_r),
        .valid_out (pk_valid),
        .num_out   (pk_num),
        .level_out (pk_lvl)
      );

      // Ceiling is the highest active level, 16 when idle
      always @*
      begin
        ceil = 5'h10;
        for (j = 5'h10; j > 5'h00; j = j - 5'h01)
        begin
          if (act_r[j[3:0] - 4'h1])
          begin
            ceil = j - 5'h01;
          end
        end
      end

      // Strictly higher level only; equal levels never nest
      assign preempt = pk_valid && {1'b0, pk_lvl} < ceil;

      // Vector port and register read feed the same acknowledge
      assign ack[c] = (vec_rd[c] || core_ack[c]) && req_r;
      assign ack_vec[512*c +: 512] = {511'h0, ack[c]} << num_r;

      // EOI pops the top, then an acknowledge pushes
      always @*
      begin
        act_nxt = act_r;
        if (eoi[c])
        begin
          act_nxt = act_nxt & (act_nxt - 16'h0001);
        end
        if (ack[c])
        begin
          act_nxt = act_nxt | (16'h0001 << lvl_r);
        end
      end

      // No memory of the last source, so repeats nest again
      always @(posedge clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          act_r <= `RST_ACT;
          req_r <= 1'b0;
          num_r <= 9'h000;
          lvl_r <= 4'h0;
        end
        else
        begin
          act_r <= act_nxt;
          // Drop for one cycle after acknowledge to avoid a stale repeat
          req_r <= ack[c] ? 1'b0 : preempt;
          if (preempt && !ack[c])
          begin
            num_r <= pk_num;
            lvl_r <= pk_lvl;
          end
        end
      end

      assign req_w[c]          = req_r;
      assign num_w[9*c +: 9]   = num_r;
      assign lvl_w[4*c +: 4]   = lvl_r;
      assign act_w[16*c +: 16] = act_r;
    end
  endgenerate

  // Read mux; unmapped addresses read zero
  always @*
  begin
    rdata_nxt = `RST_WORD;
    if (bank == `RAW_BASE >> 6)
    begin
      rdata_nxt = raw_r[{address_in[5:2], 5'h00} +: 32];
    end
    else if (bank == `EN_BASE >> 6)
    begin
      rdata_nxt = en_r[{address_in[5:2], 5'h00} +: 32];
    end
    else if (bank == `FSEL_BASE >> 6)
    begin
      rdata_nxt = fsel_r[{address_in[5:2], 5'h00} +: 32];
    end
    else if (psel == `PRIO_BASE >> 8)
    begin
      rdata_nxt = prio_r[{address_in[7:2], 5'h00} +: 32];
    end
    else if (address_in == `FIQ_VEC_OFF)
    begin
      rdata_nxt[`VEC_VALID_BIT]        = req_w[0];
      rdata_nxt[`VEC_LVL_LSB +: 4]     = lvl_w[3:0];
      rdata_nxt[`VEC_NUM_LSB +: 9]     = num_w[8:0];
    end
    else if (address_in == `IRQ_VEC_OFF)
    begin
      rdata_nxt[`VEC_VALID_BIT]        = req_w[1];
      rdata_nxt[`VEC_LVL_LSB +: 4]     = lvl_w[7:4];
      rdata_nxt[`VEC_NUM_LSB +: 9]     = num_w[17:9];
    end
    else if (address_in == `FIQ_ACT_OFF)
    begin
      rdata_nxt[15:0] = act_w[15:0];
    end
    else if (address_in == `IRQ_ACT_OFF)
    begin
      rdata_nxt[15:0] = act_w[31:16];
    end
  end

  // Fixed one wait state per transfer
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wait_r   <= 1'b1;
      rdata_r  <= `RST_WORD;
      src_s1_r <= 512'h0;
      src_s2_r <= 512'h0;
      src_s3_r <= 512'h0;
      raw_r    <= 512'h0;
      en_r     <= 512'h0;
      fsel_r   <= 512'h0;
      prio_r   <= 2048'h0;
    end
    else
    begin
      wait_r   <= !((read_in || write_in) && wait_r);
      if (rd_fire)
      begin
        rdata_r <= rdata_nxt;
      end
      src_s1_r <= src_in;
      src_s2_r <= src_s1_r;
      src_s3_r <= src_s2_r;
      raw_r    <= raw_nxt;
      en_r     <= en_nxt;
      fsel_r   <= fsel_nxt;
      prio_r   <= prio_nxt;
    end
  end

  assign readdata_out    = rdata_r;
  assign waitrequest_out = wait_r;
  assign fiq_req_out     = req_w[0];
  assign fiq_num_out     = num_w[8:0];
  assign fiq_level_out   = lvl_w[3:0];
  assign irq_req_out     = req_w[1];
  assign irq_num_out     = num_w[17:9];
  assign irq_level_out   = lvl_w[7:4];

endmodule

// ---- bench/vectored_interrupt_unit_assertions.sv ----
`timescale 1ns/100ps
`include "vectored_interrupt_map.vh"
module vectored_interrupt_unit_checker
(
  // Bus
  input logic        clk_in,
  input logic        rst_b_in,
  input logic [11:0] address_in,
  input logic        read_in,
  input logic        write_in,
  input logic        debug_access_in,
  input logic [31:0] readdata_out,
  input logic        waitrequest_out,
  // Vector ports
  input logic        fiq_ack_in,
  input logic        fiq_req_out,
  input logic        irq_ack_in,
  input logic        irq_req_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  wire rd_vec = read_in && waitrequest_out && address_in == `IRQ_VEC_OFF;
  property p_wpulse;
    !waitrequest_out |=> waitrequest_out;
  endproperty
  a_wpulse: assert property (p_wpulse) else $error("wait low");
  property p_wans;
    (read_in || write_in) && waitrequest_out |=> !waitrequest_out;
  endproperty
  a_wans: assert property (p_wans) else $error("no answer");
  property p_widle;
    !read_in && !write_in |=> waitrequest_out;
  endproperty
  a_widle: assert property (p_widle) else $error("idle answer");
  property p_fack;
    fiq_ack_in && fiq_req_out |=> !fiq_req_out;
  endproperty
  a_fack: assert property (p_fack) else $error("fast ack");
  property p_iack;
    irq_ack_in && irq_req_out |=> !irq_req_out;
  endproperty
  a_iack: assert property (p_iack) else $error("normal ack");
  property p_dbg;
    rd_vec && debug_access_in && irq_req_out && !irq_ack_in |=> irq_req_out;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug acked");
  property p_func;
    rd_vec && !debug_access_in && irq_req_out |=> !irq_req_out;
  endproperty
  a_func: assert property (p_func) else $error("read no ack");
  property p_unmap;
    read_in && waitrequest_out && address_in == 12'h3F0 |=> !readdata_out;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  c_fack: cover property (fiq_ack_in && fiq_req_out);
  c_iack: cover property (irq_ack_in && irq_req_out);
  c_dbg: cover property (rd_vec && debug_access_in);
endmodule

// ---- bench/core_vector_model.sv ----
`timescale 1ns/100ps
module core_vector_model
(
  // Clock and reset
  input  wire       clk_in,
  input  wire       rst_b_in,
  // Vector handshake
  input  wire       en_in,
  input  wire       req_in,
  input  wire [3:0] lat_in,
  output reg        ack_out
);
  reg [3:0] wait_r;
  // Latency varies so the core answers both fast and late
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ack_out <= 1'b0;
      wait_r  <= 4'h0;
    end
    else
    begin
      ack_out <= 1'b0;
      if (!en_in || !req_in || ack_out)
        wait_r <= 4'h0;
      else if (wait_r >= lat_in)
        ack_out <= 1'b1;
      else
        wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// ---- bench/vectored_interrupt_nesting_tb_top.sv ----
`timescale 1ns/100ps
`include "vectored_interrupt_map.vh"
module vectored_interrupt_nesting_tb_top;
  logic         clk_in = 1'b0;
  logic         rst_b_in, read_in, write_in, debug_access_in;
  logic [511:0] src_in;
  logic [11:0]  address_in;
  logic [31:0]  writedata_in, readdata_out;
  logic [3:0]   byteenable_in, fiq_level_out, irq_level_out, lat;
  logic         waitrequest_out, fiq_ack_in, fiq_req_out, en_i;
  logic         irq_ack_in, irq_req_out;
  logic [8:0]   fiq_num_out, irq_num_out;
  logic [31:0]  seed = 32'hA2E6B851;
  logic [31:0]  rq[$], vq[$];
  int           s[6];
  int           miscompares = 0;
  int           cmp_count = 0;

  vectored_interrupt_unit u_dut
  (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .src_in(src_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .debug_access_in(debug_access_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .fiq_ack_in(fiq_ack_in),
    .fiq_req_out(fiq_req_out), .fiq_num_out(fiq_num_out),
    .fiq_level_out(fiq_level_out), .irq_ack_in(irq_ack_in),
    .irq_req_out(irq_req_out), .irq_num_out(irq_num_out),
    .irq_level_out(irq_level_out)
  );
  core_vector_model u_core_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .en_in(en_i), .req_in(irq_req_out), .lat_in(lat), .ack_out(irq_ack_in));
  core_vector_model u_core_f (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .en_in(en_i), .req_in(fiq_req_out), .lat_in(lat), .ack_out(fiq_ack_in));

  always #5 clk_in = ~clk_in;

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [31:0] vw(input logic [8:0] n, input logic [3:0] l);
    return {1'b1, 11'h000, l, 7'h00, n};
  endfunction
  function logic [11:0] ow(input int n);
    return 12'(4 * (n / 32));
  endfunction
  function logic [31:0] bt(input int n);
    return 32'h0000_0001 << (n % 32);
  endfunction

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (e !== g)
    begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_vec(input logic [31:0] g);
    chk(vq.size() ? vq.pop_front() : 32'hFFFF_FFFF, g);
  endtask
  task automatic bus(input bit w, input bit dg, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    read_in         <= !w;
    write_in        <= w;
    address_in      <= a;
    writedata_in    <= d;
    debug_access_in <= dg;
    do
      @(posedge clk_in);
    while (waitrequest_out !== 1'b0);
    read_in  <= 1'b0;
    write_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input bit dg);
    rq.push_back(e);
    bus(1'b0, dg, a, 32'h0000_0000);
  endtask
  task automatic eoi(input logic [11:0] a);
    bus(1'b1, 1'b0, a, 32'h0000_0000);
  endtask
  task automatic cfg(input int n, input logic [3:0] l, input bit f);
    bus(1'b1, 1'b0, `EN_BASE + ow(n), bt(n));
    bus(1'b1, 1'b0, `PRIO_BASE + 12'(4 * (n / 8)), 32'(l) << 4 * (n % 8));
    bus(1'b1, 1'b0, `FSEL_BASE + ow(n), f ? bt(n) : 32'h0000_0000);
  endtask
  task automatic pin(input int n);
    @(posedge clk_in);
    src_in[n] <= 1'b1;
    lat       <= 4'(rnd());
    repeat (3) @(posedge clk_in);
    src_in[n] <= 1'b0;
  endtask
  task automatic hit(input int n, input logic [3:0] l);
    int t;
    vq.push_back(vw(9'(n), l));
    pin(n);
    for (t = 0; vq.size() && t < 60; t++)
      @(posedge clk_in);
    if (vq.size())
      chk_vec(32'h0000_0000);
  endtask
  task report_and_stop;
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    if (read_in && !waitrequest_out)
      chk(rq.size() ? rq.pop_front() : 32'hFFFF_FFFF, readdata_out);
    if (irq_ack_in && irq_req_out)
      chk_vec(vw(irq_num_out, irq_level_out));
    if (fiq_ack_in && fiq_req_out)
      chk_vec(vw(fiq_num_out, fiq_level_out));
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    {rst_b_in, read_in, write_in, debug_access_in, en_i} = 5'h00;
    src_in        = '0;
    address_in    = 12'h000;
    writedata_in  = 32'h0000_0000;
    byteenable_in = 4'hF;
    lat           = 4'h0;
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    foreach (s[k])
      s[k] = k * 64 + int'(rnd() & 32'h0000_003F);
    cfg(s[0], 4'h5, 1'b0);
    cfg(s[1], 4'h2, 1'b0);
    cfg(s[2], 4'h1, 1'b0);
    cfg(s[4], 4'h3, 1'b1);
    cfg(s[5], 4'h0, 1'b1);
    bus(1'b1, 1'b0, `RAW_BASE + ow(s[0]), bt(s[0]));
    repeat (4) @(posedge clk_in);
    rd(`IRQ_VEC_OFF, vw(9'(s[0]), 4'h5), 1'b0);
    rd(`IRQ_ACT_OFF, 32'h0000_0020, 1'b0);
    en_i <= 1'b1;
    hit(s[1], 4'h2);
    rd(`IRQ_ACT_OFF, 32'h0000_0024, 1'b0);
    eoi(`IRQ_VEC_OFF);
    hit(s[1], 4'h2);
    eoi(`IRQ_VEC_OFF);
    hit(s[2], 4'h1);
    eoi(`IRQ_VEC_OFF);
    hit(s[1], 4'h2);
    eoi(`IRQ_VEC_OFF);
    eoi(`IRQ_VEC_OFF);
    rd(`IRQ_ACT_OFF, 32'h0000_0000, 1'b0);
    en_i <= 1'b0;
    pin(s[1]);
    repeat (4) @(posedge clk_in);
    rd(`IRQ_VEC_OFF, vw(9'(s[1]), 4'h2), 1'b1);
    rd(`IRQ_VEC_OFF, vw(9'(s[1]), 4'h2), 1'b1);
    rd(`IRQ_VEC_OFF, vw(9'(s[1]), 4'h2), 1'b0);
    rd(`IRQ_ACT_OFF, 32'h0000_0004, 1'b0);
    eoi(`IRQ_VEC_OFF);
    bus(1'b1, 1'b0, `RAW_BASE + ow(s[3]), bt(s[3]));
    rd(`RAW_BASE + ow(s[3]), bt(s[3]), 1'b0);
    eoi(`RAW_BASE + ow(s[3]));
    rd(`RAW_BASE + ow(s[3]), 32'h0000_0000, 1'b0);
    en_i <= 1'b1;
    hit(s[4], 4'h3);
    hit(s[5], 4'h0);
    rd(`FIQ_ACT_OFF, 32'h0000_0009, 1'b0);
    eoi(`FIQ_VEC_OFF);
    eoi(`FIQ_VEC_OFF);
    rd(`FIQ_ACT_OFF, 32'h0000_0000, 1'b0);
    en_i <= 1'b0;
    pin(s[4]);
    repeat (4) @(posedge clk_in);
    rd(`FIQ_VEC_OFF, vw(9'(s[4]), 4'h3), 1'b0);
    rd(`FIQ_ACT_OFF, 32'h0000_0008, 1'b0);
    eoi(`FIQ_VEC_OFF);
    rd(12'h3F0, 32'h0000_0000, 1'b0);
    report_and_stop();
  end
endmodule

bind vectored_interrupt_unit vectored_interrupt_unit_checker u_chk
  (.clk_in(clk_in), .rst_b_in(rst_b_in), .address_in(address_in),
   .read_in(read_in), .write_in(write_in),
   .debug_access_in(debug_access_in), .readdata_out(readdata_out),
   .waitrequest_out(waitrequest_out), .fiq_ack_in(fiq_ack_in),
   .fiq_req_out(fiq_req_out), .irq_ack_in(irq_ack_in),
   .irq_req_out(irq_req_out));
